// ==== core/ipcwp_irq_pin_cfg_write_protect.sv ====
`timescale 1ns/1ps
// Function
// - General-output select set: pin driven steadily to the active-level bit.
// - General-output select clear: pin only signals interrupt activity.
// - Hi-Z-when-idle clear drives always; set drives only while active or while general output is selected.
// - Active-level 0 means active low; 1 means active high.
// - Pin setup register resets to 0x02.
// - Key values other than 0x85 and 0x86 block writes elsewhere.
// - Key 0x85 lets every writeable register be written.
// - Key 0x86 allows one write elsewhere, then protection returns.
// - Key register stays writable in every mode; software unlocks first.
// - Key register resets to 0x85, fully unprotected.
module ipcwp_irq_pin_cfg_write_protect (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ipcwp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ipcwp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ipcwp_pkg::SRC_W-1:0] src_pending,
   input wire logic [ipcwp_pkg::SRC_W-1:0] src_enable,
   output logic [ipcwp_pkg::DATA_W-1:0] reg_rdata,
   output logic ext_wr,
   output logic [ipcwp_pkg::ADDR_W-1:0] ext_addr,
   output logic [ipcwp_pkg::DATA_W-1:0] ext_wdata,
   output logic irq_pin_o,
   output logic irq_pin_oe
);

   // Any key value that is not one of the two open codes counts as protected.
   function automatic logic ipcwp_key_open(input logic [ipcwp_pkg::DATA_W-1:0] key);
      ipcwp_key_open = (key == ipcwp_pkg::KEY_FULL_OPEN) ||
                       (key == ipcwp_pkg::KEY_SINGLE_OPEN);
   endfunction

   logic [ipcwp_pkg::DATA_W-1:0] pin_setup;
   logic [ipcwp_pkg::DATA_W-1:0] unlock_key;
   logic [ipcwp_pkg::DATA_W-1:0] next_pin_setup;
   logic [ipcwp_pkg::DATA_W-1:0] next_unlock_key;
   logic [ipcwp_pkg::DATA_W-1:0] next_rdata;
   logic next_pin_o;
   logic next_pin_oe;

   wire sel_pin = (reg_addr == ipcwp_pkg::ADDR_PIN_SETUP);
   wire sel_key = (reg_addr == ipcwp_pkg::ADDR_UNLOCK_KEY);
   wire wr_key = reg_wr && sel_key;
   wire wr_other = reg_wr && !sel_key;
   wire write_open = ipcwp_key_open(unlock_key);
   wire wr_accept = wr_other && write_open;
   wire wr_pin = wr_accept && sel_pin;
   wire wr_ext = wr_accept && !sel_pin;
   wire single_used = wr_accept && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN);
   wire irq_active = |(src_pending & src_enable);
   wire gpo_sel = pin_setup[ipcwp_pkg::BIT_GPO_SEL];
   wire hiz_idle = pin_setup[ipcwp_pkg::BIT_HIZ_IDLE];
   wire act_level = pin_setup[ipcwp_pkg::BIT_ACTIVE_LEVEL];

   // Key write wins over the single-write relock; both cannot coincide anyway.
   assign next_unlock_key = wr_key ? reg_wdata :
                            single_used ? ipcwp_pkg::KEY_RELOCK : unlock_key;
   assign next_pin_setup = wr_pin ? (reg_wdata & ipcwp_pkg::PIN_SETUP_MASK) : pin_setup;
   // Reads never look at the key, so software can always see the protection state.
   assign next_rdata = !reg_rd ? reg_rdata :
                       sel_pin ? pin_setup :
                       sel_key ? unlock_key : ipcwp_pkg::DATA_ZERO;
   // General output forces the level; otherwise the level follows activity.
   assign next_pin_o = gpo_sel ? act_level :
                       (irq_active ? act_level : !act_level);
   assign next_pin_oe = gpo_sel || !hiz_idle || irq_active;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_setup <= ipcwp_pkg::RST_PIN_SETUP;
         unlock_key <= ipcwp_pkg::RST_UNLOCK_KEY;
         reg_rdata <= ipcwp_pkg::DATA_ZERO;
         ext_wr <= 1'b0;
         ext_addr <= ipcwp_pkg::DATA_ZERO;
         ext_wdata <= ipcwp_pkg::DATA_ZERO;
         irq_pin_o <= 1'b1;
         irq_pin_oe <= 1'b0;
      end else begin
         pin_setup <= next_pin_setup;
         unlock_key <= next_unlock_key;
         reg_rdata <= next_rdata;
         ext_wr <= wr_ext;
         ext_addr <= reg_addr;
         ext_wdata <= reg_wdata;
         irq_pin_o <= next_pin_o;
         irq_pin_oe <= next_pin_oe;
      end
   end

   AST_GPO_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      gpo_sel |=> irq_pin_oe && (irq_pin_o == $past(act_level)))
      else $error("general output pin not at active level");

   AST_IRQ_ACTIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && irq_active) |=> irq_pin_oe && (irq_pin_o == $past(act_level)))
      else $error("active interrupt not shown on pin");

   AST_HIZ_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && hiz_idle && !irq_active) |=> !irq_pin_oe)
      else $error("idle pin driven while hi-z idle set");

   AST_ALWAYS_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !hiz_idle |=> irq_pin_oe)
      else $error("pin released while always-drive selected");

   AST_IDLE_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && !irq_active) |=> (irq_pin_o != $past(act_level)))
      else $error("idle pin shows active level");

   AST_RESET_VALUES: assert property (@(posedge clk_sys)
      !rst_n ##1 !rst_n |-> (pin_setup == ipcwp_pkg::RST_PIN_SETUP) &&
      (unlock_key == ipcwp_pkg::RST_UNLOCK_KEY))
      else $error("register reset values wrong");

   AST_LOCKED_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && !ipcwp_key_open(unlock_key)) |=> !ext_wr && $stable(pin_setup))
      else $error("write passed while protected");

   AST_OPEN_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && !sel_pin && unlock_key == ipcwp_pkg::KEY_FULL_OPEN) |=>
      ext_wr && (ext_wdata == $past(reg_wdata)) && (unlock_key == ipcwp_pkg::KEY_FULL_OPEN))
      else $error("open write not passed");

   AST_SINGLE_RELOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN) ##1 wr_other && !sel_pin |=>
      !ext_wr)
      else $error("second write accepted in single mode");

   AST_KEY_WRITABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_key |=> (unlock_key == $past(reg_wdata)))
      else $error("key write not taken");

   AST_READ_KEY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && sel_key) |=> (reg_rdata == $past(unlock_key)))
      else $error("key read wrong");

   AST_SOURCE_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && !hiz_idle && ((src_pending & src_enable) == 8'h00)) |=>
      (irq_pin_o != $past(act_level)))
      else $error("masked source raised interrupt");

   AST_GPO_IGNORES_SRC: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gpo_sel && !irq_active) |=> (irq_pin_o == $past(act_level)))
      else $error("general output follows interrupt activity");

   AST_GPO_OVER_HIZ: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gpo_sel && hiz_idle && !irq_active) |=> irq_pin_oe)
      else $error("general output released by hi-z idle");

   AST_GPO_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gpo_sel && act_level) |=> irq_pin_o)
      else $error("general output not high");

   AST_GPO_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (gpo_sel && !act_level) |=> !irq_pin_o)
      else $error("general output not low");

   AST_IRQ_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && irq_active && act_level) |=> irq_pin_o)
      else $error("active high interrupt not high");

   AST_IRQ_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && irq_active && !act_level) |=> !irq_pin_o)
      else $error("active low interrupt not low");

   AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !gpo_sel |=> (irq_pin_o == ($past(irq_active) ~^ $past(act_level))))
      else $error("interrupt pin level does not follow activity");

   AST_HIZ_ACTIVE_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (hiz_idle && irq_active) |=> irq_pin_oe)
      else $error("active interrupt not driven");

   AST_OE_SOURCES: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (irq_pin_oe == ($past(gpo_sel) || !$past(hiz_idle) || $past(irq_active))))
      else $error("pin enable wrong");

   AST_ACTIVE_LOW_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && !act_level && !irq_active) |=> irq_pin_o)
      else $error("idle active low pin not high");

   AST_ACTIVE_HIGH_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && act_level && !irq_active) |=> !irq_pin_o)
      else $error("idle active high pin not low");

   AST_PIN_RST: assert property (@(posedge clk_sys)
      !rst_n ##1 !rst_n |-> irq_pin_o && !irq_pin_oe)
      else $error("pin outputs wrong in reset");

   AST_BUS_RST: assert property (@(posedge clk_sys)
      !rst_n ##1 !rst_n |-> !ext_wr && (reg_rdata == ipcwp_pkg::DATA_ZERO))
      else $error("bus outputs wrong in reset");

   AST_UPPER_BITS_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pin_setup & ~ipcwp_pkg::PIN_SETUP_MASK) == ipcwp_pkg::DATA_ZERO)
      else $error("unused pin setup bits set");

   AST_LOCKED_PIN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_pin && !ipcwp_key_open(unlock_key)) |=> $stable(pin_setup))
      else $error("pin setup written while protected");

   AST_LOCKED_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && !sel_key && !sel_pin && !ipcwp_key_open(unlock_key)) |=> !ext_wr)
      else $error("forwarded write while protected");

   AST_LOCKED_KEY_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!wr_key && !ipcwp_key_open(unlock_key)) |=> $stable(unlock_key))
      else $error("protected key changed without key write");

   AST_OPEN_PIN_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_pin && (unlock_key == ipcwp_pkg::KEY_FULL_OPEN)) |=>
      (pin_setup == ($past(reg_wdata) & ipcwp_pkg::PIN_SETUP_MASK)))
      else $error("open pin setup write lost");

   AST_OPEN_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && !sel_pin && (unlock_key == ipcwp_pkg::KEY_FULL_OPEN)) |=>
      (ext_addr == $past(reg_addr)))
      else $error("forwarded address wrong");

   AST_OPEN_STAYS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!wr_key && (unlock_key == ipcwp_pkg::KEY_FULL_OPEN)) |=>
      (unlock_key == ipcwp_pkg::KEY_FULL_OPEN))
      else $error("full open key changed by itself");

   AST_EXT_ONLY_ON_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reg_wr |=> !ext_wr)
      else $error("forward strobe without write");

   AST_EXT_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_wr |=> (ext_wdata == $past(reg_wdata)))
      else $error("forwarded data wrong");

   AST_SINGLE_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN)) |=>
      (unlock_key == ipcwp_pkg::KEY_RELOCK))
      else $error("single write did not relock");

   AST_SINGLE_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && !sel_pin && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN)) |=> ext_wr)
      else $error("single write not forwarded");

   AST_SINGLE_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_pin && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN)) |=>
      (pin_setup == ($past(reg_wdata) & ipcwp_pkg::PIN_SETUP_MASK)))
      else $error("single pin setup write lost");

   AST_SINGLE_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!reg_wr && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN)) |=>
      (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN))
      else $error("single open key lost without write");

   AST_RELOCK_BLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_other && (unlock_key == ipcwp_pkg::KEY_RELOCK)) |=> !ext_wr)
      else $error("write passed after relock");

   AST_KEY_FROM_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_key && !ipcwp_key_open(unlock_key)) |=> (unlock_key == $past(reg_wdata)))
      else $error("key write refused while protected");

   AST_KEY_FROM_SINGLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_key && (unlock_key == ipcwp_pkg::KEY_SINGLE_OPEN)) |=>
      (unlock_key == $past(reg_wdata)))
      else $error("key write refused in single mode");

   AST_KEY_NO_EXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_key |=> !ext_wr)
      else $error("key write forwarded");

   AST_KEY_NO_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_key |=> $stable(pin_setup))
      else $error("key write changed pin setup");

   AST_READ_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && sel_pin) |=> (reg_rdata == $past(pin_setup)))
      else $error("pin setup read wrong");

   AST_READ_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && !sel_pin && !sel_key) |=> (reg_rdata == ipcwp_pkg::DATA_ZERO))
      else $error("unmapped read not zero");

   AST_READ_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");

   AST_READ_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && sel_pin && !ipcwp_key_open(unlock_key)) |=>
      (reg_rdata == $past(pin_setup)))
      else $error("read blocked by protection");

   AST_PENDING_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && (src_enable == '0)) |=> (irq_pin_o != $past(act_level)))
      else $error("disabled sources raised interrupt");

   AST_PENDING_ENABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!gpo_sel && |(src_pending & src_enable)) |=> (irq_pin_o == $past(act_level)))
      else $error("enabled pending source not shown");

   AST_PENDING_DRIVES: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|(src_pending & src_enable)) |=> irq_pin_oe)
      else $error("pending source left pin undriven");

endmodule // ipcwp_irq_pin_cfg_write_protect

// ==== core/ipcwp_pkg.sv ====
package ipcwp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SRC_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_PIN_SETUP = 8'h7D;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK_KEY = 8'h7E;
   localparam logic [DATA_W-1:0] RST_PIN_SETUP = 8'h02;
   localparam logic [DATA_W-1:0] RST_UNLOCK_KEY = 8'h85;
   localparam logic [DATA_W-1:0] KEY_FULL_OPEN = 8'h85;
   localparam logic [DATA_W-1:0] KEY_SINGLE_OPEN = 8'h86;
   localparam logic [DATA_W-1:0] KEY_RELOCK = 8'h00;
   localparam logic [DATA_W-1:0] PIN_SETUP_MASK = 8'h07;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam int BIT_ACTIVE_LEVEL = 0;
   localparam int BIT_HIZ_IDLE = 1;
   localparam int BIT_GPO_SEL = 2;
endpackage

// ==== verif/ipcwp_host_model.sv ====
`timescale 1ns/1ps
module ipcwp_host_model (
   input wire logic clk_sys,
   output logic [ipcwp_pkg::ADDR_W-1:0] reg_addr,
   output logic [ipcwp_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   // One strobe cycle per access; released lines show the inverse so stale data never helps.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // Two writes on consecutive edges, strobe held high between them.
   task automatic acc2(input logic [7:0] a1, d1, a2, d2);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_rd <= 1'h0;
      reg_addr <= a1;
      reg_wdata <= d1;
      @(posedge clk_sys);
      reg_addr <= a2;
      reg_wdata <= d2;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      reg_addr <= ~a2;
      reg_wdata <= ~d2;
   endtask
endmodule // ipcwp_host_model

// ==== verif/irq_pin_cfg_write_protect_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module irq_pin_cfg_write_protect_tb;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] src_pending = 8'hff;
   logic [7:0] src_enable = 8'h00;
   logic [7:0] b_addr, b_wdata, rdata, ext_addr, ext_wdata;
   logic b_wr, b_rd, ext_wr, irq_pin_o, irq_pin_oe;
   int err_total = 0;
   int checked = 0;
   always #2.5 clk_sys = ~clk_sys;
   ipcwp_host_model host (.clk_sys(clk_sys), .reg_addr(b_addr), .reg_wdata(b_wdata),
      .reg_wr(b_wr), .reg_rd(b_rd));
   ipcwp_irq_pin_cfg_write_protect dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(b_addr),
      .reg_wdata(b_wdata), .reg_wr(b_wr), .reg_rd(b_rd), .src_pending(src_pending),
      .src_enable(src_enable), .reg_rdata(rdata), .ext_wr(ext_wr), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host.acc(1'h1, a, d);
      #1;
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      host.acc(1'h0, a, 8'h00);
      #1;
      `CHK("reg_rdata", e, rdata)
   endtask
   task automatic t_reset;
      `CHK("irq_pin_oe", 1'h0, irq_pin_oe)
      `CHK("irq_pin_o", 1'h1, irq_pin_o)
      r(8'h7d, 8'h02);
      r(8'h7e, 8'h85);
   endtask
   task automatic t_pin;
      logic [2:0] c;
      for (int i = 0; i < 16; i++) begin
         c = i[3:1];
         w(8'h7d, {5'h1f, c});
         @(posedge clk_sys);
         src_enable <= i[0] ? 8'h10 : 8'h00;
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK("irq_pin_o", c[2] ? c[0] : (i[0] ? c[0] : !c[0]), irq_pin_o)
         `CHK("irq_pin_oe", c[2] | !c[1] | i[0], irq_pin_oe)
      end
      r(8'h7d, 8'h07);
   endtask
   task automatic t_protect;
      logic [7:0] k [4] = '{8'h84, 8'h85, 8'h86, 8'h87};
      logic [7:0] cur = 8'h07;
      foreach (k[j]) begin
         w(8'h7e, k[j]);
         w(8'h10, k[j]);
         `CHK("ext_wr", k[j] inside {8'h85, 8'h86}, ext_wr)
         `CHK("ext_wdata", k[j], ext_wdata)
         `CHK("ext_addr", 8'h10, ext_addr)
         w(8'h7d, 8'(j));
         `CHK("ext_wr", 1'h0, ext_wr)
         if (k[j] == 8'h85) begin
            cur = 8'(j);
         end
         r(8'h7d, cur);
         r(8'h7e, k[j] == 8'h86 ? 8'h00 : k[j]);
      end
   endtask
   task automatic t_burst;
      w(8'h7e, 8'h86);
      host.acc2(8'h7d, 8'h05, 8'h10, 8'h33);
      #1;
      `CHK("ext_wr", 1'h0, ext_wr)
      r(8'h7d, 8'h05);
      r(8'h7e, 8'h00);
   endtask
   task automatic t_rerst;
      @(posedge clk_sys);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("irq_pin_oe", 1'h1, irq_pin_oe)
      `CHK("irq_pin_o", 1'h0, irq_pin_o)
      r(8'h7d, 8'h02);
      r(8'h7e, 8'h85);
   endtask
   task automatic test_done;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_reset();
      t_pin();
      t_protect();
      t_burst();
      t_rerst();
      test_done();
   end
endmodule // irq_pin_cfg_write_protect_tb
